// [hw/flash_seq_pkg.sv]
/*
  constants, register map and state types of the flash self-program controller.
  assumes one 8-bit register port and a row-organised array of 14-bit words.
*/
package flash_seq_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [2:0] OFS_ADDR_LO = 3'h0;
  localparam logic [2:0] OFS_ADDR_HI = 3'h1;
  localparam logic [2:0] OFS_DATA_LO = 3'h2;
  localparam logic [2:0] OFS_DATA_HI = 3'h3;
  localparam logic [2:0] OFS_CTRL = 3'h4;
  localparam logic [2:0] OFS_KEY = 3'h5;
  localparam logic [2:0] OFS_STAT = 3'h6;
  // ****************************************
  // field positions of flash_ctrl_reg and status
  // ****************************************
  localparam int CTRL_RD = 0;
  localparam int CTRL_WR = 1;
  localparam int CTRL_MODEN = 2;
  localparam int CTRL_FAULT = 3;
  localparam int CTRL_FREE = 4;
  localparam int CTRL_LATCH = 5;
  localparam int CTRL_REGS = 6;
  localparam int STAT_DONE = 0;
  localparam int STAT_IE = 1;
  // ****************************************
  // values
  // ****************************************
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [13:0] BLANK_WORD = 14'h3FFF;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [7:0] ADDR_LO_RST = 8'h00;
  localparam logic [6:0] ADDR_HI_RST = 7'h00;
  localparam logic [13:0] DATA_RST = 14'h0000;
  localparam int ROW_WORDS = 32;
  localparam logic [4:0] LAST_LATCH = 5'h1F;
  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [2:0] {OP_IDLE, OP_READ, OP_ERASE, OP_PROG, OP_PWAIT} op_t;
  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT55, KEY_GOTAA} key_t;
endpackage : flash_seq_pkg

// [hw/flash_self_program_control.sv]
/*
  flash self-program controller: unlock tracker, row erase, write latches,
  row program and word read. assumes the array, its timer and the core's
  interrupt entry share mclk; arr_done is a one-cycle pulse from the array.
*/
// Behaviour
// [RQ1] key 55h, AAh, then program-go, in order
// [RQ2] erase, load, program need completed unlock
// [RQ3] broken unlock loads nothing, programs nothing
// [RQ4] cpu stalled until the operation ends
// [RQ5] software masks interrupts around the unlock
// [RQ6] erase whole rows only, never automatically
// [RQ7] software selects region, row, erase, enable
// [RQ8] protected erase clears go, no erase
// [RQ9] erase end sets done flag, irq if enabled
// [RQ10] erase keeps latches and modify enable
// [RQ11] software programs only erased words
// [RQ12] at most 32 words per program
// [RQ13] address splits into row and latch index
// [RQ14] latches blank 3FFFh after every program
// [RQ15] latch-only loads one latch, else programs row
// [RQ16] unloaded latches stay blank
// [RQ17] software loads latches then programs last
// [RQ18] read stalls, data next cycle, bit self-clears
// [RQ19] fault on protected go, reset, broken unlock
// [RQ20] erase hits whole row, data ignored
// [RQ21] out-of-order access returns tracker to idle
// [RQ22] go needs modify enable already set
module flash_self_program_control (
  // clock and resets
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic warm_rst_req,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // core
  input wire logic irq_entry,
  output logic cpu_stall,
  output logic op_irq,
  // write protection
  input wire logic wp_en,
  input wire logic [14:0] wp_limit,
  // flash array
  output logic arr_rd,
  output logic arr_erase,
  output logic arr_word_we,
  output logic arr_space,
  output logic [14:0] arr_addr,
  output logic [13:0] arr_wdata,
  input wire logic [13:0] arr_rdata,
  input wire logic arr_done
);
  typedef struct packed {
    flash_seq_pkg::op_t op;
    flash_seq_pkg::key_t key;
    logic [7:0] adl;
    logic [6:0] adh;
    logic [13:0] dat;
    logic [6:0] ctrl;
    logic done;
    logic ie;
    logic [4:0] idx;
    logic [flash_seq_pkg::ROW_WORDS-1:0][13:0] lat;
    logic [7:0] rdata;
    logic stall;
    logic rd_o;
    logic er_o;
    logic we_o;
    logic irq;
    logic [14:0] aaddr;
    logic [13:0] awd;
  } st_t;

  st_t s;
  st_t n;
  logic key_wr;
  logic ctl_wr;
  logic brk;
  logic unlock;
  logic prot;
  logic busy;

  // ****************************************
  // next state
  // ****************************************
  // one combinational pass; later assignments take priority over earlier ones
  always_comb begin
    n = s;
    n.er_o = 1'b0;
    n.we_o = 1'b0;
    n.rd_o = 1'b0;
    n.rdata = 8'h00;
    key_wr = reg_wr && (reg_addr == flash_seq_pkg::OFS_KEY);
    ctl_wr = reg_wr && (reg_addr == flash_seq_pkg::OFS_CTRL);
    busy = (s.op == flash_seq_pkg::OP_ERASE) || (s.op == flash_seq_pkg::OP_PROG) ||
      (s.op == flash_seq_pkg::OP_PWAIT);
    // register writes; go and read-start are handled below
    if (reg_wr) begin
      case (reg_addr)
        flash_seq_pkg::OFS_ADDR_LO: n.adl = reg_wdata;
        flash_seq_pkg::OFS_ADDR_HI: n.adh = reg_wdata[6:0];
        flash_seq_pkg::OFS_DATA_LO: n.dat[7:0] = reg_wdata;
        flash_seq_pkg::OFS_DATA_HI: n.dat[13:8] = reg_wdata[5:0];
        flash_seq_pkg::OFS_CTRL: begin
          n.ctrl[flash_seq_pkg::CTRL_REGS] = reg_wdata[flash_seq_pkg::CTRL_REGS];
          n.ctrl[flash_seq_pkg::CTRL_LATCH] = reg_wdata[flash_seq_pkg::CTRL_LATCH];
          n.ctrl[flash_seq_pkg::CTRL_FREE] = reg_wdata[flash_seq_pkg::CTRL_FREE];
          n.ctrl[flash_seq_pkg::CTRL_FAULT] = reg_wdata[flash_seq_pkg::CTRL_FAULT];
          n.ctrl[flash_seq_pkg::CTRL_MODEN] = reg_wdata[flash_seq_pkg::CTRL_MODEN];
          if (reg_wdata[flash_seq_pkg::CTRL_RD]) begin
            n.ctrl[flash_seq_pkg::CTRL_RD] = 1'b1;
          end
        end
        flash_seq_pkg::OFS_STAT: begin
          n.done = reg_wdata[flash_seq_pkg::STAT_DONE];
          n.ie = reg_wdata[flash_seq_pkg::STAT_IE];
        end
        default: ;
      endcase
    end
    // [RQ13] row from the upper ten bits
    prot = wp_en && !n.ctrl[flash_seq_pkg::CTRL_REGS] && ({n.adh, n.adl} < wp_limit);
    // [RQ21] any other access breaks the sequence
    brk = irq_entry || reg_rd || (reg_wr && !key_wr && !ctl_wr) ||
      (ctl_wr && !reg_wdata[flash_seq_pkg::CTRL_WR]);
    unlock = 1'b0;
    case (s.key)
      flash_seq_pkg::KEY_IDLE: begin
        // [RQ1] first key opens the sequence
        if (key_wr && reg_wdata == flash_seq_pkg::KEY_FIRST) begin
          n.key = flash_seq_pkg::KEY_GOT55;
        end
      end
      flash_seq_pkg::KEY_GOT55: begin
        // an interrupt in the same cycle as the key still breaks it
        if (key_wr && reg_wdata == flash_seq_pkg::KEY_SECOND && !irq_entry) begin
          n.key = flash_seq_pkg::KEY_GOTAA;
        end else if (key_wr || ctl_wr || brk) begin
          // [RQ19] broken unlock flags a fault
          n.key = flash_seq_pkg::KEY_IDLE;
          n.ctrl[flash_seq_pkg::CTRL_FAULT] = 1'b1;
        end
      end
      flash_seq_pkg::KEY_GOTAA: begin
        if (ctl_wr && reg_wdata[flash_seq_pkg::CTRL_WR] && !irq_entry) begin
          unlock = 1'b1;
          n.key = flash_seq_pkg::KEY_IDLE;
        end else if (key_wr || brk) begin
          // [RQ3] no load, no program after a break
          n.key = flash_seq_pkg::KEY_IDLE;
          n.ctrl[flash_seq_pkg::CTRL_FAULT] = 1'b1;
        end
      end
      default: n.key = flash_seq_pkg::KEY_IDLE;
    endcase
    // [RQ2] erase, load and program start only from a completed unlock
    // [RQ22] modify enable must already be set
    if (unlock && s.ctrl[flash_seq_pkg::CTRL_MODEN] && s.op == flash_seq_pkg::OP_IDLE) begin
      if (n.ctrl[flash_seq_pkg::CTRL_FREE] || !n.ctrl[flash_seq_pkg::CTRL_LATCH]) begin
        if (prot) begin
          // [RQ8] protected target: go cleared, fault set
          n.ctrl[flash_seq_pkg::CTRL_FAULT] = 1'b1;
        end else if (n.ctrl[flash_seq_pkg::CTRL_FREE]) begin
          // [RQ20] erase the row, data registers ignored
          // [RQ6] one whole row per go
          // [RQ4] core stalled until the array answers
          n.op = flash_seq_pkg::OP_ERASE;
          n.er_o = 1'b1;
          n.aaddr = {n.adh, n.adl[7:5], 5'h00};
          n.ctrl[flash_seq_pkg::CTRL_WR] = 1'b1;
          n.stall = 1'b1;
        end else begin
          // [RQ15] whole latch row goes to the array
          n.op = flash_seq_pkg::OP_PROG;
          n.idx = 5'h00;
          n.ctrl[flash_seq_pkg::CTRL_WR] = 1'b1;
          n.stall = 1'b1;
        end
      end else begin
        // [RQ15] latch-only load ignores protection
        n.lat[n.adl[4:0]] = n.dat;
      end
    end
    // read start; a pending read waits until the sequencer is idle
    if (n.ctrl[flash_seq_pkg::CTRL_RD] && n.op == flash_seq_pkg::OP_IDLE) begin
      // [RQ18] stall and present the address
      n.op = flash_seq_pkg::OP_READ;
      n.rd_o = 1'b1;
      n.aaddr = {n.adh, n.adl};
      n.stall = 1'b1;
    end
    case (s.op)
      flash_seq_pkg::OP_READ: begin
        // [RQ18] data captured, bit cleared by hardware
        n.dat = arr_rdata;
        n.ctrl[flash_seq_pkg::CTRL_RD] = 1'b0;
        n.op = flash_seq_pkg::OP_IDLE;
        n.stall = 1'b0;
      end
      flash_seq_pkg::OP_ERASE: begin
        // [RQ9] completion sets the done flag
        // [RQ10] latches and modify enable untouched
        if (arr_done) begin
          n.done = 1'b1;
          n.ctrl[flash_seq_pkg::CTRL_WR] = 1'b0;
          n.ctrl[flash_seq_pkg::CTRL_FREE] = 1'b0;
          n.op = flash_seq_pkg::OP_IDLE;
          n.stall = 1'b0;
        end
      end
      flash_seq_pkg::OP_PROG: begin
        // [RQ12] one word per cycle, 32 in all
        // [RQ13] row fixed, latch index counts
        n.we_o = 1'b1;
        n.aaddr = {s.adh, s.adl[7:5], s.idx};
        n.awd = s.lat[s.idx];
        n.idx = s.idx + 5'h01;
        if (s.idx == flash_seq_pkg::LAST_LATCH) begin
          n.op = flash_seq_pkg::OP_PWAIT;
        end
      end
      flash_seq_pkg::OP_PWAIT: begin
        if (arr_done) begin
          // [RQ14] blank all latches after programming
          // [RQ16] unloaded latches stay blank
          n.lat = {flash_seq_pkg::ROW_WORDS{flash_seq_pkg::BLANK_WORD}};
          n.done = 1'b1;
          n.ctrl[flash_seq_pkg::CTRL_WR] = 1'b0;
          n.op = flash_seq_pkg::OP_IDLE;
          n.stall = 1'b0;
        end
      end
      default: ;
    endcase
    // warm reset aborts everything; a self-write in flight leaves a fault
    if (warm_rst_req) begin
      n.op = flash_seq_pkg::OP_IDLE;
      n.key = flash_seq_pkg::KEY_IDLE;
      n.ctrl = flash_seq_pkg::CTRL_RST | {3'h0, s.ctrl[flash_seq_pkg::CTRL_FAULT], 3'h0};
      n.stall = 1'b0;
      n.er_o = 1'b0;
      n.we_o = 1'b0;
      n.rd_o = 1'b0;
      // [RQ19] reset during self-write
      if (busy) begin
        n.ctrl[flash_seq_pkg::CTRL_FAULT] = 1'b1;
      end
    end
    // read data stand in the cycle after the strobe only
    if (reg_rd) begin
      case (reg_addr)
        flash_seq_pkg::OFS_ADDR_LO: n.rdata = s.adl;
        flash_seq_pkg::OFS_ADDR_HI: n.rdata = {1'b1, s.adh};
        flash_seq_pkg::OFS_DATA_LO: n.rdata = s.dat[7:0];
        flash_seq_pkg::OFS_DATA_HI: n.rdata = {2'h0, s.dat[13:8]};
        flash_seq_pkg::OFS_CTRL: n.rdata = {1'b0, s.ctrl};
        flash_seq_pkg::OFS_STAT: n.rdata = {6'h00, s.ie, s.done};
        default: n.rdata = 8'h00;
      endcase
    end
    // [RQ9] interrupt when done and enabled
    n.irq = n.done && n.ie;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.op <= flash_seq_pkg::OP_IDLE;
      s.key <= flash_seq_pkg::KEY_IDLE;
      s.adl <= flash_seq_pkg::ADDR_LO_RST;
      s.adh <= flash_seq_pkg::ADDR_HI_RST;
      s.dat <= flash_seq_pkg::DATA_RST;
      s.ctrl <= flash_seq_pkg::CTRL_RST;
      s.lat <= {flash_seq_pkg::ROW_WORDS{flash_seq_pkg::BLANK_WORD}};
    end else begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = s.rdata;
  assign cpu_stall = s.stall;
  assign op_irq = s.irq;
  assign arr_rd = s.rd_o;
  assign arr_erase = s.er_o;
  assign arr_word_we = s.we_o;
  assign arr_space = s.ctrl[flash_seq_pkg::CTRL_REGS];
  assign arr_addr = s.aaddr;
  assign arr_wdata = s.awd;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  key_order_a: assert property ($rose(busy) |-> // [RQ1]
    $past(unlock) && $past(s.key) == flash_seq_pkg::KEY_GOTAA) else $error("no unlock");
  latch_gate_a: assert property ($changed(s.lat) |-> // [RQ2]
    $past(unlock) || $past(s.op) == flash_seq_pkg::OP_PWAIT) else $error("latch changed unlocked");
  stall_busy_a: assert property (busy |-> cpu_stall) else $error("cpu not stalled"); // [RQ4]
  erase_only_a: assert property (arr_erase |-> s.op == flash_seq_pkg::OP_ERASE && // [RQ6]
    arr_addr[4:0] == 5'h00) else $error("erase outside row erase");
  wp_block_a: assert property (unlock && prot && s.ctrl[flash_seq_pkg::CTRL_MODEN] && // [RQ8]
    !warm_rst_req && s.op == flash_seq_pkg::OP_IDLE && n.ctrl[flash_seq_pkg::CTRL_FREE]
    |=> !arr_erase && s.ctrl[flash_seq_pkg::CTRL_FAULT]) else $error("protected erase ran");
  erase_done_a: assert property (s.op == flash_seq_pkg::OP_ERASE && arr_done && // [RQ9]
    !warm_rst_req |=> s.done && !cpu_stall ##1 op_irq == s.ie) else $error("erase end lost");
  erase_keep_a: assert property (s.op == flash_seq_pkg::OP_ERASE && !warm_rst_req |=> // [RQ10]
    $stable(s.lat) && $stable(s.ctrl[flash_seq_pkg::CTRL_MODEN])) else $error("erase side effect");
  prog_len_a: assert property ($rose(s.op == flash_seq_pkg::OP_PROG) |-> s.idx == 5'h00) // [RQ12]
    else $error("program count bad start");
  row_addr_a: assert property (arr_word_we |-> arr_addr[14:5] == {s.adh, s.adl[7:5]} && // [RQ13]
    arr_addr[4:0] == s.idx - 5'h01) else $error("word outside row");
  blank_after_a: assert property (s.op == flash_seq_pkg::OP_PWAIT && arr_done && // [RQ14]
    !warm_rst_req |=> s.lat == {flash_seq_pkg::ROW_WORDS{flash_seq_pkg::BLANK_WORD}})
    else $error("latches not blanked");
  read_ret_a: assert property (s.op == flash_seq_pkg::OP_IDLE && ctl_wr && !warm_rst_req && // [RQ18]
    !unlock && reg_wdata[flash_seq_pkg::CTRL_RD] |=> arr_rd ##1
    !s.ctrl[flash_seq_pkg::CTRL_RD] && !cpu_stall) else $error("read sequence wrong");
  break_fault_a: assert property (s.key == flash_seq_pkg::KEY_GOT55 && irq_entry && // [RQ19]
    !warm_rst_req |=> s.key == flash_seq_pkg::KEY_IDLE && s.ctrl[flash_seq_pkg::CTRL_FAULT])
    else $error("break not flagged");
  enable_gate_a: assert property (unlock && !s.ctrl[flash_seq_pkg::CTRL_MODEN] |=> // [RQ22]
    $stable(s.lat) && !cpu_stall) else $error("go without enable");

  erase_c: cover property (arr_erase ##[1:50] s.done);
  prog_c: cover property (s.op == flash_seq_pkg::OP_PWAIT && arr_done);
  load_c: cover property (unlock ##1 $changed(s.lat));
endmodule : flash_self_program_control

// [test/test_flash_self_program_control.sv]
/*
  self-checking bench of the flash self-program controller, playing core and array.
  assumes the design package is compiled first and the array answers on mclk.
*/
module test_flash_self_program_control;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // signals and stand-in array state
  // ****************************************
  localparam logic [2:0] ALO = flash_seq_pkg::OFS_ADDR_LO;
  localparam logic [2:0] AHI = flash_seq_pkg::OFS_ADDR_HI;
  localparam logic [2:0] DLO = flash_seq_pkg::OFS_DATA_LO;
  localparam logic [2:0] DHI = flash_seq_pkg::OFS_DATA_HI;
  localparam logic [2:0] CTRL = flash_seq_pkg::OFS_CTRL;
  localparam logic [2:0] KEY = flash_seq_pkg::OFS_KEY;
  localparam logic [2:0] STAT = flash_seq_pkg::OFS_STAT;
  logic mclk, rst_n, warm_rst_req, reg_wr, reg_rd, irq_entry, wp_en, arr_done;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic cpu_stall, op_irq, arr_rd, arr_erase, arr_word_we, arr_space;
  logic [14:0] wp_limit, arr_addr, last_addr;
  logic [13:0] arr_wdata, arr_rdata;
  logic [13:0] words [32];
  int wcnt = 0;
  int ecnt = 0;
  int rdcnt = 0;
  int busy_cnt = 0;
  int failures = 0;
  int comparisons = 0;

  flash_self_program_control dut_u (
    .mclk(mclk), .rst_n(rst_n), .warm_rst_req(warm_rst_req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_entry(irq_entry), .cpu_stall(cpu_stall),
    .op_irq(op_irq), .wp_en(wp_en), .wp_limit(wp_limit), .arr_rd(arr_rd),
    .arr_erase(arr_erase), .arr_word_we(arr_word_we), .arr_space(arr_space),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata),
    .arr_done(arr_done)
  );

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // array stand-in: records words and erases, answers a few cycles later
  always @(posedge mclk) begin
    arr_done <= 1'b0;
    if (busy_cnt == 1) arr_done <= 1'b1;
    if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
    if (arr_word_we) begin
      words[arr_addr[4:0]] <= arr_wdata;
      last_addr <= arr_addr;
      wcnt <= wcnt + 1;
      if (arr_addr[4:0] == 5'h1F) busy_cnt <= 4;
    end
    if (arr_erase) begin
      ecnt <= ecnt + 1;
      last_addr <= arr_addr;
      busy_cnt <= 4;
    end
    if (arr_rd) rdcnt <= rdcnt + 1;
  end
  // ****************************************
  // access tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle write strobe, always a free cycle before it
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(16'(reg_rdata & m), 16'(e));
  endtask : rdchk

  // key pair then go write; brk lets the core take an interrupt mid-way
  task automatic unlock(input logic [7:0] c, input logic brk);
    wr(KEY, flash_seq_pkg::KEY_FIRST);
    if (brk) begin
      @(posedge mclk);
      irq_entry <= 1'b1;
      @(posedge mclk);
      irq_entry <= 1'b0;
      rdchk(CTRL, 8'h08, 8'h08);
    end
    wr(KEY, flash_seq_pkg::KEY_SECOND);
    wr(CTRL, c);
  endtask : unlock

  // counts stalled cycles; bounded so a stuck stall cannot hang the run
  task automatic wait_idle(output int n);
    n = 0;
    for (int i = 0; i < 300; i++) begin
      @(negedge mclk);
      if (cpu_stall === 1'b1) n++;
      else if (i > 2) break;
    end
  endtask : wait_idle

  task automatic give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #500000;
    failures++;
    give_verdict();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int n;
    rst_n = 1'b0;
    warm_rst_req = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    irq_entry = 1'b0;
    wp_en = 1'b0;
    wp_limit = 15'h0000;
    arr_rdata = 14'h2B3C;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk(AHI, 8'hFF, 8'h80);
    rdchk(3'h7, 8'hFF, 8'h00);
    // latch-only load of one word
    wr(AHI, 8'h02);
    wr(ALO, 8'h45);
    wr(DLO, 8'h34);
    wr(DHI, 8'h12);
    wr(CTRL, 8'h24);
    unlock(8'h26, 1'b0);
    wait_idle(n);
    chk(16'(n), 16'h0000);
    chk(16'(wcnt), 16'h0000);
    rdchk(CTRL, 8'hFF, 8'h24);
    // erase of the row about to be programmed, done flag and irq
    wr(STAT, 8'h02);
    wr(ALO, 8'h4B);
    wr(CTRL, 8'h14);
    unlock(8'h16, 1'b0);
    wait_idle(n);
    chk(16'(n != 0), 16'h0001);
    chk(16'(ecnt), 16'h0001);
    chk(16'(last_addr), 16'h0240);
    rdchk(CTRL, 8'hFF, 8'h04);
    rdchk(STAT, 8'hFF, 8'h03);
    chk(16'(op_irq), 16'h0001);
    wr(STAT, 8'h00);
    // program of the erased row keeps the latch loaded before the erase
    wr(ALO, 8'h45);
    wr(CTRL, 8'h04);
    unlock(8'h06, 1'b0);
    wait_idle(n);
    chk(16'(n >= 32), 16'h0001);
    chk(16'(wcnt), 16'd32);
    chk(16'(last_addr[14:5]), 16'h0012);
    chk(16'(words[5]), 16'h1234);
    chk(16'(words[0]), 16'h3FFF);
    unlock(8'h06, 1'b0);
    wait_idle(n);
    for (int i = 0; i < 32; i++) chk(16'(words[i]), 16'h3FFF);
    // interrupted, reordered or unenabled unlocks do nothing
    wr(CTRL, 8'h04);
    unlock(8'h06, 1'b1);
    wait_idle(n);
    chk(16'(wcnt), 16'd64);
    rdchk(CTRL, 8'h0A, 8'h00);
    wr(KEY, flash_seq_pkg::KEY_SECOND);
    wr(KEY, flash_seq_pkg::KEY_FIRST);
    wr(CTRL, 8'h06);
    wait_idle(n);
    chk(16'(wcnt), 16'd64);
    rdchk(CTRL, 8'h0A, 8'h08);
    wr(CTRL, 8'h04);
    unlock(8'h06, 1'b0);
    wait_idle(n);
    chk(16'(wcnt), 16'd96);
    wr(CTRL, 8'h00);
    unlock(8'h06, 1'b0);
    wait_idle(n);
    chk(16'(wcnt), 16'd96);
    // protected erase refused with fault
    @(posedge mclk);
    wp_en <= 1'b1;
    wp_limit <= 15'h7FFF;
    wr(CTRL, 8'h14);
    unlock(8'h16, 1'b0);
    wait_idle(n);
    chk(16'(ecnt), 16'h0001);
    rdchk(CTRL, 8'h0A, 8'h08);
    @(posedge mclk);
    wp_en <= 1'b0;
    // warm reset in the middle of an erase leaves a fault
    wr(STAT, 8'h00);
    wr(CTRL, 8'h14);
    unlock(8'h16, 1'b0);
    @(posedge mclk);
    warm_rst_req <= 1'b1;
    @(posedge mclk);
    warm_rst_req <= 1'b0;
    wait_idle(n);
    chk(16'(ecnt), 16'h0002);
    rdchk(CTRL, 8'hFF, 8'h08);
    rdchk(STAT, 8'hFF, 8'h00);
    // region select reaches the array, then a word read lands in the data pair
    wr(CTRL, 8'h40);
    @(negedge mclk);
    chk(16'(arr_space), 16'h0001);
    wr(CTRL, 8'h00);
    wr(CTRL, 8'h01);
    wait_idle(n);
    chk(16'(n), 16'h0001);
    chk(16'(rdcnt), 16'h0001);
    rdchk(DLO, 8'hFF, 8'h3C);
    rdchk(DHI, 8'hFF, 8'h2B);
    rdchk(CTRL, 8'hFF, 8'h00);
    chk(16'(arr_space), 16'h0000);
    give_verdict();
  end
endmodule : test_flash_self_program_control
